// ---- hw/orient_pkg.sv ----
// orientation status reporter: register map, field layout, reset values
// assumes a 32-bit ahb-lite slave with word-aligned registers
// the ADDR_ values are register indices; the bus byte address is four times the index
package orient_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h10;  // orientation status, read clears
  localparam logic [7:0] ADDR_CONFIG = 8'h11;  // detect enable at bit 6
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;  // interrupt source, sticky
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;  // interrupt enable mask
  localparam int BIT_CHANGE = 7;
  localparam int BIT_TILT = 6;
  localparam int BIT_PL_HI = 2;
  localparam int BIT_PL_LO = 1;
  localparam int BIT_BF = 0;
  localparam int BIT_ENABLE = 6;
  localparam int BIT_IRQ_ORIENT = 4;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [1:0] PL_PORTRAIT_UP = 2'h0;
  localparam logic [1:0] PL_PORTRAIT_DOWN = 2'h1;
  localparam logic [1:0] PL_LANDSCAPE_RIGHT = 2'h2;
  localparam logic [1:0] PL_LANDSCAPE_LEFT = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  // 1.25g expressed in accel counts: 1g = 256 counts in a 2g full scale
  localparam logic [9:0] LOCK_LIMIT = 10'h140;
endpackage

// ---- hw/orientation_status_reporter.sv ----
//
// Contract
// RULE_01 - bit 7 flags any orientation field change
// RULE_02 - first result after activation sets change flag
// RULE_03 - status read clears change flag
// RULE_04 - status read drops pending orientation interrupt
// RULE_05 - bit 6 reports z tilt lockout
// RULE_06 - bits 2:1 hold portrait/landscape code
// RULE_07 - bit 0 is back/front facing
// RULE_08 - all fields zero after reset
// RULE_09 - fields keep updating while flag set
// RULE_10 - freeze orientation above 1.25g on any axis
// RULE_11 - interrupt source bit set when flag and enabled
// RULE_12 - detection only while enable bit is one
// RULE_13 - bits 5:3 read zero, writes ignored
//
// orientation status register file behind an ahb-lite slave
// assumes the detector core delivers one result pulse per output sample,
// and that active mode and axis magnitudes are synchronous to clk_sys
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module orientation_status_reporter #(
  parameter int ACC_W = 10
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             hsel,
  input  wire logic [7:0]       haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic             active_mode,
  input  wire logic             result_valid,
  input  wire logic [1:0]       result_pl_code,
  input  wire logic             result_back,
  input  wire logic             result_tilt,
  input  wire logic [ACC_W-1:0] abs_x,
  input  wire logic [ACC_W-1:0] abs_y,
  input  wire logic [ACC_W-1:0] abs_z,
  output logic                  irq
);
  logic       orient_change_flag;
  logic       z_tilt_exceeded;
  logic [1:0] portrait_landscape_code;
  logic       back_front_flag;
  logic       orient_detect_enable;
  logic       dbcnt_mode;
  logic       orient_irq_source;
  logic       irq_mask;
  logic       active_q;
  logic       first_pending;
  logic       ph_valid;
  logic       ph_write;
  logic [7:0] ph_addr;
  logic       over_limit;
  logic       take;
  logic       accept;
  logic       status_read;
  logic       changed;
  logic       set_change;
  logic [7:0] status_byte;

  // magnitude beyond the lock limit on one axis
  function automatic logic above_limit(input logic [ACC_W-1:0] mag);
    return mag > ACC_W'(orient_pkg::LOCK_LIMIT);
  endfunction

  // bus byte address to register index; the low two bits only pick a byte lane
  function automatic logic [7:0] reg_index(input logic [7:0] addr);
    return {2'b00, addr[7:2]};
  endfunction

  assign over_limit = above_limit(abs_x) | above_limit(abs_y) | above_limit(abs_z);
  // results only count when enabled and not locked by a large acceleration
  assign take = result_valid & orient_detect_enable & ~over_limit;  // see RULE_10 see RULE_12
  assign changed = (result_pl_code != portrait_landscape_code) |
                   (result_back != back_front_flag) | (result_tilt != z_tilt_exceeded);
  assign set_change = take & (changed | first_pending);  // see RULE_01 see RULE_02
  assign accept = hsel & hready & (htrans == orient_pkg::HTRANS_NONSEQ ||
                                   htrans == orient_pkg::HTRANS_SEQ);
  assign status_read = ph_valid & ~ph_write & (ph_addr == orient_pkg::ADDR_STATUS);

  // reserved bits 5:3 tie to zero
  always_comb begin
    status_byte = orient_pkg::STATUS_RESET;  // see RULE_13
    status_byte[orient_pkg::BIT_CHANGE] = orient_change_flag;  // see RULE_01
    status_byte[orient_pkg::BIT_TILT] = z_tilt_exceeded;  // see RULE_05
    status_byte[orient_pkg::BIT_PL_HI:orient_pkg::BIT_PL_LO] = portrait_landscape_code;  // see RULE_06
    status_byte[orient_pkg::BIT_BF] = back_front_flag;  // see RULE_07
  end

  // address phase capture; slave never waits, so data phase is one cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ph_valid <= accept;
      ph_write <= hwrite;
      ph_addr <= reg_index(haddr);  // register index, not byte address
    end
  end

  // zero-wait, always okay; hsize is ignored since only words are used
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read data registered in the address phase so hrdata is a flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (accept && !hwrite) begin
      case (reg_index(haddr))
        orient_pkg::ADDR_STATUS: hrdata <= {24'h00_0000, status_byte};
        orient_pkg::ADDR_CONFIG: hrdata <= {24'h00_0000, dbcnt_mode, orient_detect_enable, 6'h00};
        orient_pkg::ADDR_IRQ_STATUS: hrdata <= {27'h000_0000, orient_irq_source, 4'h0};
        orient_pkg::ADDR_IRQ_MASK: hrdata <= {27'h000_0000, irq_mask, 4'h0};
        default: hrdata <= 32'h0000_0000;
      endcase
    end else begin
      hrdata <= 32'h0000_0000;
    end
  end

  // writable configuration; status and irq status ignore writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      orient_detect_enable <= 1'b0;  // see RULE_12
      dbcnt_mode <= 1'b1;
      irq_mask <= 1'b0;
    end else if (ph_valid && ph_write) begin
      if (ph_addr == orient_pkg::ADDR_CONFIG) begin
        orient_detect_enable <= hwdata[orient_pkg::BIT_ENABLE];
        dbcnt_mode <= hwdata[orient_pkg::BIT_CHANGE];
      end
      if (ph_addr == orient_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= hwdata[orient_pkg::BIT_IRQ_ORIENT];
      end
    end
  end

  // arm the first-result flag on every standby to active edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      first_pending <= 1'b0;
    end else begin
      active_q <= active_mode;
      if (active_mode && !active_q) begin
        first_pending <= 1'b1;  // see RULE_02
      end else if (take) begin
        first_pending <= 1'b0;
      end
    end
  end

  // fields follow results even while the change flag is pending
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      portrait_landscape_code <= orient_pkg::PL_PORTRAIT_UP;  // see RULE_08
      back_front_flag <= 1'b0;
      z_tilt_exceeded <= 1'b0;
    end else if (take) begin
      portrait_landscape_code <= result_pl_code;  // see RULE_09
      back_front_flag <= result_back;
      z_tilt_exceeded <= result_tilt;
    end
  end

  // change flag: a new event in the read cycle wins over the clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      orient_change_flag <= 1'b0;  // see RULE_08
    end else if (set_change) begin
      orient_change_flag <= 1'b1;  // see RULE_01
    end else if (status_read) begin
      orient_change_flag <= 1'b0;  // see RULE_03
    end
  end

  // sticky interrupt source, gated by mask; cleared by the status read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      orient_irq_source <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (set_change && irq_mask) begin
        orient_irq_source <= 1'b1;  // see RULE_11
      end else if (status_read) begin
        orient_irq_source <= 1'b0;  // see RULE_04
      end
      irq <= orient_irq_source & irq_mask;
    end
  end

  property p_read_clears;
    @(posedge clk_sys) disable iff (!rst_n)
      (status_read && !set_change) |=> !orient_change_flag;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag survived read");  // see RULE_03

  property p_irq_clears;
    @(posedge clk_sys) disable iff (!rst_n)
      (status_read && !set_change) |=> !orient_irq_source ##1 !irq;
  endproperty
  a_irq_clears: assert property (p_irq_clears) else $error("irq survived read");  // see RULE_04

  property p_change_sets;
    @(posedge clk_sys) disable iff (!rst_n)
      (take && changed) |=> orient_change_flag;
  endproperty
  a_change_sets: assert property (p_change_sets) else $error("change not flagged");  // see RULE_01

  property p_first_result;
    @(posedge clk_sys) disable iff (!rst_n)
      (first_pending && take && !(active_mode && !active_q)) |=>
        orient_change_flag && !first_pending;
  endproperty
  a_first_result: assert property (p_first_result) else $error("first result missed");  // see RULE_02

  property p_freeze;
    @(posedge clk_sys) disable iff (!rst_n)
      over_limit |=> $stable(portrait_landscape_code) && $stable(back_front_flag)
                     && $stable(z_tilt_exceeded);
  endproperty
  a_freeze: assert property (p_freeze) else $error("orientation moved above limit");  // see RULE_10

  property p_disabled;
    @(posedge clk_sys) disable iff (!rst_n)
      !orient_detect_enable |=> $stable(portrait_landscape_code) && !$rose(orient_change_flag);
  endproperty
  a_disabled: assert property (p_disabled) else $error("update while disabled");  // see RULE_12

  property p_track;
    @(posedge clk_sys) disable iff (!rst_n)
      (take && orient_change_flag) |=> portrait_landscape_code == $past(result_pl_code);
  endproperty
  a_track: assert property (p_track) else $error("fields frozen by flag");  // see RULE_09

  property p_irq_level;
    @(posedge clk_sys) disable iff (!rst_n)
      (set_change && irq_mask) |=> orient_irq_source ##1 irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not raised");  // see RULE_11

  property p_reserved;
    @(posedge clk_sys) disable iff (!rst_n)
      (accept && !hwrite && reg_index(haddr) == orient_pkg::ADDR_STATUS) |=> hrdata[31:3] ==
        {24'h00_0000, $past(orient_change_flag), $past(z_tilt_exceeded), 3'h0};
  endproperty
  a_reserved: assert property (p_reserved) else $error("status readback wrong");  // see RULE_13

  // fields only move on an accepted result, so a lockout or disable cannot leak
  property p_hold_idle;
    @(posedge clk_sys) disable iff (!rst_n)
      !take |=> $stable(portrait_landscape_code) && $stable(back_front_flag)
                && $stable(z_tilt_exceeded);
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("field moved idle");  // see RULE_10

  property p_follow;
    @(posedge clk_sys) disable iff (!rst_n)
      take |=> {z_tilt_exceeded, portrait_landscape_code, back_front_flag} ==
               $past({result_tilt, result_pl_code, result_back});
  endproperty
  a_follow: assert property (p_follow) else $error("result not stored");  // see RULE_06

  property p_set_only;
    @(posedge clk_sys) disable iff (!rst_n)
      !set_change |=> !$rose(orient_change_flag);
  endproperty
  a_set_only: assert property (p_set_only) else $error("flag rose unbidden");  // see RULE_01

  property p_irq_lag;
    @(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> irq == $past(orient_irq_source && irq_mask);
  endproperty
  a_irq_lag: assert property (p_irq_lag) else $error("irq level wrong");  // see RULE_11

  property p_status_ro;
    @(posedge clk_sys) disable iff (!rst_n)
      (ph_valid && ph_write && ph_addr == orient_pkg::ADDR_STATUS && !set_change) |=>
        $stable(status_byte);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status took a write");  // see RULE_13

  property p_hrdata_idle;
    @(posedge clk_sys) disable iff (!rst_n)
      !(accept && !hwrite) |=> hrdata == 32'h0000_0000;
  endproperty
  a_hrdata_idle: assert property (p_hrdata_idle) else $error("stale read data");  // see RULE_13

  property p_arm;
    @(posedge clk_sys) disable iff (!rst_n)
      (active_mode && !active_q) |=> first_pending;
  endproperty
  a_arm: assert property (p_arm) else $error("activation not armed");  // see RULE_02
endmodule
`default_nettype wire

// ---- test/orient_host_model.sv ----
// host side of the register bus: a single ahb-lite master doing word transfers
// assumes hready is the one slave's hreadyout and callers enter right after a clock edge
`timescale 1ns/100ps
`default_nettype none
module orient_host_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  output logic             hsel,
  output logic [7:0]       haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // idle bus from time zero
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // byte address is four times the register index, since the ADDR_ values are register indices, not byte addresses
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {idx[5:0], 2'b00};
    htrans <= orient_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd;  // released data must not keep looking valid
  endtask
endmodule
`default_nettype wire

// ---- test/orientation_status_reporter_test.sv ----
// self-checking bench for the orientation status reporter
// assumes the host model drives the bus; the bench acts as the detector core
`timescale 1ns/100ps
`default_nettype none
module orientation_status_reporter_test;
  logic        clk_sys, rst_n, active_mode, result_valid, result_back, result_tilt;
  logic [1:0]  result_pl_code;
  logic [9:0]  abs_x, abs_y, abs_z;
  logic [9:0]  lv [6];
  wire logic   hsel, hwrite, hreadyout, hresp, irq;
  wire logic [7:0]  haddr;
  wire logic [1:0]  htrans;
  wire logic [2:0]  hsize;
  wire logic [31:0] hwdata, hrdata;
  logic [31:0] rd;
  logic [3:0]  f;
  integer      mismatches, check_count, seed;
  int          fld, flag, src, armed, msk, en;

  orientation_status_reporter #(.ACC_W(10)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .active_mode(active_mode), .result_valid(result_valid), .result_pl_code(result_pl_code),
    .result_back(result_back), .result_tilt(result_tilt), .abs_x(abs_x), .abs_y(abs_y),
    .abs_z(abs_z), .irq(irq));
  orient_host_model host (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // irq level is compared after the two-cycle lag has run out
  task automatic chk_irq();
    chk("irq", {31'h0, 1'(src != 0 && msk != 0)}, {31'h0, irq});
  endtask

  function automatic logic [31:0] stat();
    return {24'h0, 1'(flag), fld[3], 3'h0, fld[2:0]};
  endfunction

  // a read returns the model's status and then clears flag and source
  task automatic read_status();
    host.xfer(1'b0, orient_pkg::ADDR_STATUS, 32'h0, rd);
    chk("status", stat(), rd);
    chk("hresp", 32'h0, {31'h0, hresp});
    flag = 0;
    src = 0;
    repeat (3) @(posedge clk_sys);
    chk_irq();
  endtask

  // one detector result; frozen only when an axis is strictly above the limit
  task automatic send(input logic [3:0] v, input logic [9:0] ax, ay, az);
    result_valid <= 1'b1;
    {result_tilt, result_pl_code, result_back} <= v;
    abs_x <= ax;
    abs_y <= ay;
    abs_z <= az;
    @(posedge clk_sys);
    result_valid <= 1'b0;
    if (en != 0 && ax <= 10'h140 && ay <= 10'h140 && az <= 10'h140) begin
      if (armed != 0 || int'(v) != fld) begin
        flag = 1;
        if (msk != 0) src = 1;
      end
      fld = int'(v);
      armed = 0;
    end
    repeat (3) @(posedge clk_sys);
    chk_irq();
  endtask

  task automatic activate();
    active_mode <= 1'b0;
    @(posedge clk_sys);
    active_mode <= 1'b1;
    armed = 1;
    @(posedge clk_sys);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    complete_run();
  end

  initial begin
    {rst_n, active_mode, result_valid, result_back, result_tilt} = 5'b0;
    result_pl_code = 2'h0;
    {abs_x, abs_y, abs_z} = 30'h0;
    lv = '{10'h010, 10'h140, 10'h141, 10'h0A0, 10'h13F, 10'h000};
    {mismatches, check_count, fld, flag, src, armed, msk, en} = 0;
    seed = 3;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    read_status();
    host.xfer(1'b0, 8'h3F, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    host.xfer(1'b0, orient_pkg::ADDR_CONFIG, 32'h0, rd);
    chk("config", 32'h0000_0080, rd);
    $display("test reset done");
    // first result after activation with unchanged fields, mask off
    host.xfer(1'b1, orient_pkg::ADDR_CONFIG, 32'h0000_0040, rd);
    host.xfer(1'b0, orient_pkg::ADDR_CONFIG, 32'h0, rd);
    chk("config", 32'h0000_0040, rd);
    en = 1;
    activate();
    send(4'h0, 10'h010, 10'h010, 10'h010);
    host.xfer(1'b0, orient_pkg::ADDR_IRQ_STATUS, 32'h0, rd);
    chk("irq source", 32'h0, rd);
    read_status();
    host.xfer(1'b1, orient_pkg::ADDR_IRQ_MASK, 32'h0000_0010, rd);
    host.xfer(1'b0, orient_pkg::ADDR_IRQ_MASK, 32'h0, rd);
    chk("mask", 32'h0000_0010, rd);
    msk = 1;
    $display("test first result done");
    // random results, freezes just above the limit, reads only every other result
    for (int i = 0; i < 32; i++) begin
      if (i % 8 == 7) activate();
      f = 4'($random(seed));
      send(f, lv[$unsigned($random(seed)) % 6], lv[$unsigned($random(seed)) % 6],
           lv[$unsigned($random(seed)) % 6]);
      if (i % 4 == 1) begin
        host.xfer(1'b0, orient_pkg::ADDR_IRQ_STATUS, 32'h0, rd);
        chk("irq source", {27'h0, 1'(src), 4'h0}, rd);
      end
      if (i % 2 == 1) read_status();
    end
    $display("test random results done");
    // writes to the status register change nothing
    host.xfer(1'b1, orient_pkg::ADDR_STATUS, 32'hFFFF_FFFF, rd);
    read_status();
    // detection disabled: results are ignored
    host.xfer(1'b1, orient_pkg::ADDR_CONFIG, 32'h0000_0000, rd);
    en = 0;
    send(4'(fld) ^ 4'hF, 10'h0, 10'h0, 10'h0);
    read_status();
    $display("test disable done");
    complete_run();
  end
endmodule
`default_nettype wire
